// [include/iqc_pkg.sv]
// Constants and types for the interrupt and conversion control block
package iqc_pkg;

	// ****************************************
	// Geometry and register map
	// ****************************************
	localparam int unsigned NPORT = 12;
	localparam logic [4:0] NO_PORT = 5'h0c;
	localparam logic [7:0] OFS_MASK = 8'h00;
	localparam logic [7:0] OFS_EDGE_A = 8'h04;
	localparam logic [7:0] OFS_EDGE_B = 8'h08;
	localparam logic [7:0] OFS_EDGE_C = 8'h0c;
	localparam logic [7:0] OFS_DEVCTL = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_PRESET_A = 8'h18;
	localparam logic [7:0] OFS_PRESET_B = 8'h1c;
	localparam logic [7:0] OFS_ADC_CFG = 8'h20;
	localparam logic [7:0] OFS_DAC_CFG = 8'h24;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int B_FLAG = 0;
	localparam int B_ADR = 1;
	localparam int B_ADM = 2;
	localparam int B_GDR = 3;
	localparam int B_GDM = 4;
	localparam int B_OVC = 5;
	localparam int B_TINT = 6;
	localparam int B_TA = 9;
	localparam int B_TB = 12;
	localparam int B_HV = 15;
	localparam int B_ADCMODE = 0;
	localparam int B_DACMODE = 2;
	localparam int B_RATE = 4;
	localparam int EDGE_A_LSB = 4;
	localparam int EDGE_B_LSB = 6;
	localparam int EDGE_C_LSB = 0;
	localparam int ST_GPI_LSB = 16;

	// ****************************************
	// Reset values and writable bits
	// ****************************************
	localparam logic [15:0] RST_MASK = 16'hffff;
	localparam logic [15:0] RST_EDGE = 16'h0000;
	localparam logic [15:0] RST_DEVCTL = 16'h0000;
	localparam logic [15:0] EDGE_A_BITS = 16'hfff0;
	localparam logic [15:0] EDGE_B_BITS = 16'hffc0;
	localparam logic [15:0] EDGE_C_BITS = 16'h0003;
	localparam logic [15:0] DEVCTL_BITS = 16'h003f;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_NS = 20;
	localparam int INT_PULSE_NS = 100;
	localparam logic [2:0] INT_PULSE_CYC = 3'(INT_PULSE_NS / CLK_NS);
	localparam int RATE0_KSPS = 200;
	localparam int RATE1_KSPS = 250;
	localparam int RATE2_KSPS = 333;
	localparam int RATE3_KSPS = 400;
	localparam logic [7:0] CONV0_CYC = 8'(1000000 / (RATE0_KSPS * CLK_NS));
	localparam logic [7:0] CONV1_CYC = 8'(1000000 / (RATE1_KSPS * CLK_NS));
	localparam logic [7:0] CONV2_CYC = 8'(1000000 / (RATE2_KSPS * CLK_NS));
	localparam logic [7:0] CONV3_CYC = 8'(1000000 / (RATE3_KSPS * CLK_NS));
	localparam int DAC_SLOT_NS = 1000;
	localparam logic [5:0] DAC_SLOT_CYC = 6'(DAC_SLOT_NS / CLK_NS);
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic {ADC_IDLE, ADC_CONV} iqc_adc_state_t;
	typedef struct packed {
		logic       start;
		logic [3:0] port;
	} iqc_conv_cmd_t;
	typedef struct packed {
		logic        stb;
		logic        preset;
		logic [3:0]  port;
		logic [11:0] value;
	} iqc_dac_cmd_t;
	typedef struct packed {
		logic       hv_supply_alarm;
		logic [2:0] ext_temp_b_irq;
		logic [2:0] ext_temp_a_irq;
		logic [2:0] internal_temp_irq;
		logic       driver_overcurrent_irq;
		logic       adc_data_missed_irq;
		logic       adc_data_ready_irq;
	} iqc_ext_irq_t;

endpackage

// [hdl/iqc_top.sv]
// Interrupt masking, input edge events and ADC/DAC mode control
// Summary of operation
// RULE1: Sweep flag drives int_n low only while its mask bit 0 is clear.
// RULE2: Continuous sweep pulses int_n low 100 ns at each sweep end regardless.
// RULE3: Mask bit 1 gates the ADC data-ready source.
// RULE4: Mask bit 2 gates the ADC data-missed source.
// RULE5: Mask bit 3 blocks input events from int_n whatever the edge modes.
// RULE6: Mask bit 4 clears only when mask bit 3 is clear too.
// RULE7: Mask bit 5 gates the driver overcurrent source.
// RULE8: Bits 8:6, 11:9, 14:12 gate the three temperature sources bit by bit.
// RULE9: Mask bit 15 gates the high-voltage supply alarm.
// RULE10: Twelve 2-bit edge codes spread over three registers.
// RULE11: Code 01 rising, 10 falling, 11 either edge sets input status.
// RULE12: Code 00 never sets that port's input status.
// RULE13: Conversion mode 00 keeps the ADC idle.
// RULE14: Mode 01: each trigger starts one ascending sweep of ADC ports.
// RULE15: Mode 10: each trigger converts one port, stepping upward and wrapping.
// RULE16: Mode 11 sweeps forever and ignores the trigger.
// RULE17: Output mode 00 refreshes DAC ports in turn.
// RULE18: Output mode 01 updates the newly written port next, then continues.
// RULE19: Host spaces immediate update requests by at least 80 us.
// RULE20: Output modes 10 and 11 drive presets A and B on every DAC port.
// RULE21: Rate field selects 200, 250, 333 or 400 ksps conversion pacing.
// RULE22: Input status records events whatever the masks.
// RULE23: int_n is low while any unmasked source is asserted.
`timescale 1ns/1ns
module iqc_top (
	// Clock and reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// AXI4-Lite write channels
	input  wire logic [7:0]           awaddr,
	input  wire logic                 awvalid,
	output logic                      awready,
	input  wire logic [31:0]          wdata,
	input  wire logic [3:0]           wstrb,
	input  wire logic                 wvalid,
	output logic                      wready,
	output logic [1:0]                bresp,
	output logic                      bvalid,
	input  wire logic                 bready,
	// AXI4-Lite read channels
	input  wire logic [7:0]           araddr,
	input  wire logic                 arvalid,
	output logic                      arready,
	output logic [31:0]               rdata,
	output logic [1:0]                rresp,
	output logic                      rvalid,
	input  wire logic                 rready,
	// Event sources and inputs
	input  wire logic                 conversion_trigger,
	input  wire logic [11:0]          gpi_in,
	input  wire iqc_pkg::iqc_ext_irq_t ext_irq,
	input  wire logic                 dac_new_data,
	input  wire logic [3:0]           dac_new_port,
	// Results
	output logic                      int_n,
	output iqc_pkg::iqc_conv_cmd_t    adc_cmd,
	output iqc_pkg::iqc_dac_cmd_t     dac_cmd
);

	// ****************************************
	// Functions
	// ****************************************
	// Lowest configured port at or above a start index
	function automatic logic [4:0] next_port(input logic [11:0] m, input logic [4:0] from);
		logic [4:0] r;
		r = iqc_pkg::NO_PORT;
		for (int i = 11; i >= 0; i--) begin
			if (m[i] && 5'(i) >= from) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction

	// Byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [15:0] r;
		r = old;
		if (s[0]) begin
			r[7:0] = d[7:0];
		end
		if (s[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction

	// ****************************************
	// Registers and wires
	// ****************************************
	logic [15:0]   mask_q;
	logic [15:0]   edge_a_q;
	logic [15:0]   edge_b_q;
	logic [15:0]   edge_c_q;
	logic [15:0]   devctl_q;
	logic [11:0]   preset_a_q;
	logic [11:0]   preset_b_q;
	logic [11:0]   adc_cfg_q;
	logic [11:0]   dac_cfg_q;
	logic [7:0]    aw_addr_q;
	logic [31:0]   w_data_q;
	logic [3:0]    w_strb_q;
	logic [11:0]   gpi_st_q;
	logic [11:0]   gpi_prev_q;
	logic          gmiss_q;
	logic          flag_q;
	logic          trig_prev_q;
	logic          sweep_done_q;
	logic [2:0]    pulse_cnt_q;
	logic [7:0]    tmr_q;
	logic [4:0]    cur_q;
	logic [4:0]    single_ptr_q;
	logic          sweep_q;
	logic [5:0]    dtmr_q;
	logic [4:0]    dptr_q;
	iqc_pkg::iqc_adc_state_t state_q;
	logic          do_wr;
	logic          rd_take;
	logic          st_clr;
	logic [1:0]    adc_mode;
	logic [1:0]    dac_mode;
	logic [7:0]    per_cyc;
	logic          trig_rise;
	logic [4:0]    p_first;
	logic [4:0]    p_next;
	logic [4:0]    p_single;
	logic [4:0]    d_next;
	logic [4:0]    d_first;
	logic [11:0]   gpi_ev;
	logic [15:0]   irq_vec;
	logic [15:0]   mask_new;
	logic [31:0]   rd_val;
	logic          rd_ok;

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	// A write lands once both address and data are held and no response is open
	assign do_wr = ~awready & ~wready & ~bvalid;
	assign rd_take = arvalid & arready;
	assign st_clr = rd_take & (araddr == iqc_pkg::OFS_STATUS);

	// Write address and data are taken independently, in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= iqc_pkg::RESP_OKAY;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
			if (do_wr) begin
				bvalid <= 1'b1;
				bresp <= rd_ok_w(aw_addr_q) ? iqc_pkg::RESP_OKAY : iqc_pkg::RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// Address decode shared by both directions
	function automatic logic rd_ok_w(input logic [7:0] a);
		return (a <= iqc_pkg::OFS_DAC_CFG) && (a[1:0] == 2'h0);
	endfunction

	// Read mux; reserved bits read as zero
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_ok = rd_ok_w(araddr);
		case (araddr)
			iqc_pkg::OFS_MASK: rd_val[15:0] = mask_q;
			iqc_pkg::OFS_EDGE_A: rd_val[15:0] = edge_a_q;
			iqc_pkg::OFS_EDGE_B: rd_val[15:0] = edge_b_q;
			iqc_pkg::OFS_EDGE_C: rd_val[15:0] = edge_c_q;
			iqc_pkg::OFS_DEVCTL: rd_val[15:0] = devctl_q;
			iqc_pkg::OFS_STATUS: begin
				rd_val[15:0] = irq_vec;
				rd_val[iqc_pkg::ST_GPI_LSB +: 12] = gpi_st_q;
			end
			iqc_pkg::OFS_PRESET_A: rd_val[11:0] = preset_a_q;
			iqc_pkg::OFS_PRESET_B: rd_val[11:0] = preset_b_q;
			iqc_pkg::OFS_ADC_CFG: rd_val[11:0] = adc_cfg_q;
			iqc_pkg::OFS_DAC_CFG: rd_val[11:0] = dac_cfg_q;
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// Read data is captured when the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= iqc_pkg::RESP_OKAY;
		end else if (rd_take) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_val;
			rresp <= rd_ok ? iqc_pkg::RESP_OKAY : iqc_pkg::RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	// Event-missed mask may fall only together with a clear event-ready mask
	always_comb begin
		mask_new = merge(mask_q, w_data_q, w_strb_q);
		mask_new[iqc_pkg::B_GDM] = mask_new[iqc_pkg::B_GDM]
			| (mask_q[iqc_pkg::B_GDM] & mask_new[iqc_pkg::B_GDR]); // [RULE6]
	end

	// Register writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_q <= iqc_pkg::RST_MASK;
			edge_a_q <= iqc_pkg::RST_EDGE;
			edge_b_q <= iqc_pkg::RST_EDGE;
			edge_c_q <= iqc_pkg::RST_EDGE;
			devctl_q <= iqc_pkg::RST_DEVCTL;
			preset_a_q <= 12'h000;
			preset_b_q <= 12'h000;
			adc_cfg_q <= 12'h000;
			dac_cfg_q <= 12'h000;
		end else if (do_wr) begin
			case (aw_addr_q)
				iqc_pkg::OFS_MASK: mask_q <= mask_new;
				iqc_pkg::OFS_EDGE_A: edge_a_q <= merge(edge_a_q, w_data_q, w_strb_q)
					& iqc_pkg::EDGE_A_BITS; // [RULE10]
				iqc_pkg::OFS_EDGE_B: edge_b_q <= merge(edge_b_q, w_data_q, w_strb_q)
					& iqc_pkg::EDGE_B_BITS; // [RULE10]
				iqc_pkg::OFS_EDGE_C: edge_c_q <= merge(edge_c_q, w_data_q, w_strb_q)
					& iqc_pkg::EDGE_C_BITS; // [RULE10]
				iqc_pkg::OFS_DEVCTL: devctl_q <= merge(devctl_q, w_data_q, w_strb_q)
					& iqc_pkg::DEVCTL_BITS;
				iqc_pkg::OFS_PRESET_A: preset_a_q <=
					12'(merge({4'h0, preset_a_q}, w_data_q, w_strb_q));
				iqc_pkg::OFS_PRESET_B: preset_b_q <=
					12'(merge({4'h0, preset_b_q}, w_data_q, w_strb_q));
				iqc_pkg::OFS_ADC_CFG: adc_cfg_q <=
					12'(merge({4'h0, adc_cfg_q}, w_data_q, w_strb_q));
				iqc_pkg::OFS_DAC_CFG: dac_cfg_q <=
					12'(merge({4'h0, dac_cfg_q}, w_data_q, w_strb_q));
				default: ;
			endcase
		end
	end

	assign adc_mode = devctl_q[iqc_pkg::B_ADCMODE +: 2];
	assign dac_mode = devctl_q[iqc_pkg::B_DACMODE +: 2];

	// ****************************************
	// Input edge events
	// ****************************************
	// Per-port edge code decides which transitions count
	always_comb begin
		logic [1:0] code;
		logic       rise;
		logic       fall;
		code = 2'h0;
		rise = 1'b0;
		fall = 1'b0;
		gpi_ev = 12'h000;
		for (int i = 0; i < 12; i++) begin
			if (i < 6) begin
				code = edge_a_q[iqc_pkg::EDGE_A_LSB + 2 * i +: 2]; // [RULE10]
			end else if (i < 11) begin
				code = edge_b_q[iqc_pkg::EDGE_B_LSB + 2 * (i - 6) +: 2];
			end else begin
				code = edge_c_q[iqc_pkg::EDGE_C_LSB +: 2];
			end
			rise = gpi_in[i] & ~gpi_prev_q[i];
			fall = ~gpi_in[i] & gpi_prev_q[i];
			gpi_ev[i] = (code[0] & rise) | (code[1] & fall); // [RULE11] [RULE12]
		end
	end

	// Status ignores masks; a new event beats a same-cycle clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gpi_prev_q <= 12'h000;
			gpi_st_q <= 12'h000;
			gmiss_q <= 1'b0;
		end else begin
			gpi_prev_q <= gpi_in;
			gpi_st_q <= (gpi_st_q & {12{~st_clr}}) | gpi_ev; // [RULE22]
			gmiss_q <= (gmiss_q & ~st_clr) | (|(gpi_ev & gpi_st_q));
		end
	end

	// ****************************************
	// ADC sequencer
	// ****************************************
	assign trig_rise = conversion_trigger & ~trig_prev_q;
	assign p_first = next_port(adc_cfg_q, 5'h00);
	assign p_next = next_port(adc_cfg_q, 5'(cur_q + 5'h01));

	// Single-conversion pointer wraps back to the lowest port
	always_comb begin
		p_single = next_port(adc_cfg_q, single_ptr_q);
		if (p_single == iqc_pkg::NO_PORT) begin
			p_single = p_first;
		end
	end

	// Conversion pacing from the rate field
	always_comb begin
		case (devctl_q[iqc_pkg::B_RATE +: 2]) // [RULE21]
			2'h0: per_cyc = iqc_pkg::CONV0_CYC;
			2'h1: per_cyc = iqc_pkg::CONV1_CYC;
			2'h2: per_cyc = iqc_pkg::CONV2_CYC;
			default: per_cyc = iqc_pkg::CONV3_CYC;
		endcase
	end

	// Triggers arriving mid-conversion are dropped, not queued
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= iqc_pkg::ADC_IDLE;
			trig_prev_q <= 1'b0;
			adc_cmd <= '0;
			tmr_q <= 8'h00;
			cur_q <= 5'h00;
			single_ptr_q <= 5'h00;
			sweep_q <= 1'b0;
			sweep_done_q <= 1'b0;
		end else begin
			trig_prev_q <= conversion_trigger;
			adc_cmd.start <= 1'b0;
			sweep_done_q <= 1'b0;
			if (adc_mode == 2'h0) begin
				state_q <= iqc_pkg::ADC_IDLE; // [RULE13]
				single_ptr_q <= 5'h00;
			end else begin
				case (state_q)
					iqc_pkg::ADC_IDLE: begin
						if ((adc_mode == 2'h3 || (adc_mode == 2'h1 && trig_rise))
							&& p_first != iqc_pkg::NO_PORT) begin // [RULE14] [RULE16]
							adc_cmd <= '{start: 1'b1, port: p_first[3:0]};
							cur_q <= p_first;
							sweep_q <= 1'b1;
							tmr_q <= 8'(per_cyc - 8'h01);
							state_q <= iqc_pkg::ADC_CONV;
						end else if (adc_mode == 2'h2 && trig_rise
							&& p_single != iqc_pkg::NO_PORT) begin // [RULE15]
							adc_cmd <= '{start: 1'b1, port: p_single[3:0]};
							single_ptr_q <= 5'(p_single + 5'h01);
							sweep_q <= 1'b0;
							tmr_q <= 8'(per_cyc - 8'h01);
							state_q <= iqc_pkg::ADC_CONV;
						end
					end
					iqc_pkg::ADC_CONV: begin
						if (tmr_q != 8'h00) begin
							tmr_q <= 8'(tmr_q - 8'h01);
						end else if (sweep_q && p_next != iqc_pkg::NO_PORT) begin
							adc_cmd <= '{start: 1'b1, port: p_next[3:0]}; // [RULE14]
							cur_q <= p_next;
							tmr_q <= 8'(per_cyc - 8'h01);
						end else begin
							sweep_done_q <= sweep_q;
							state_q <= iqc_pkg::ADC_IDLE;
						end
					end
					default: state_q <= iqc_pkg::ADC_IDLE;
				endcase
			end
		end
	end

	// ****************************************
	// DAC refresh sequencer
	// ****************************************
	assign d_first = next_port(dac_cfg_q, 5'h00);

	// Slot port with wrap to the lowest DAC port
	always_comb begin
		d_next = next_port(dac_cfg_q, dptr_q);
		if (d_next == iqc_pkg::NO_PORT) begin
			d_next = d_first;
		end
	end

	// One port refreshed per slot; a new write in mode 01 jumps the queue
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dtmr_q <= 6'h00;
			dptr_q <= 5'h00;
			dac_cmd <= '0;
		end else begin
			dac_cmd.stb <= 1'b0;
			if (dac_mode == 2'h1 && dac_new_data && dac_cfg_q[dac_new_port]) begin
				dptr_q <= {1'b0, dac_new_port}; // [RULE18]
				dtmr_q <= 6'h00;
			end else if (dtmr_q != 6'h00) begin
				dtmr_q <= 6'(dtmr_q - 6'h01);
			end else if (d_next != iqc_pkg::NO_PORT) begin
				dac_cmd.stb <= 1'b1; // [RULE17]
				dac_cmd.port <= d_next[3:0];
				dac_cmd.preset <= dac_mode[1]; // [RULE20]
				dac_cmd.value <= dac_mode[0] ? preset_b_q : preset_a_q;
				dptr_q <= 5'(d_next + 5'h01);
				dtmr_q <= 6'(iqc_pkg::DAC_SLOT_CYC - 6'h01);
			end
		end
	end

	// ****************************************
	// Interrupt line
	// ****************************************
	// Source vector shares bit positions with the mask register
	always_comb begin
		irq_vec = 16'h0000;
		irq_vec[iqc_pkg::B_FLAG] = flag_q;
		irq_vec[iqc_pkg::B_ADR] = ext_irq.adc_data_ready_irq;
		irq_vec[iqc_pkg::B_ADM] = ext_irq.adc_data_missed_irq;
		irq_vec[iqc_pkg::B_GDR] = |gpi_st_q;
		irq_vec[iqc_pkg::B_GDM] = gmiss_q;
		irq_vec[iqc_pkg::B_OVC] = ext_irq.driver_overcurrent_irq;
		irq_vec[iqc_pkg::B_TINT +: 3] = ext_irq.internal_temp_irq;
		irq_vec[iqc_pkg::B_TA +: 3] = ext_irq.ext_temp_a_irq;
		irq_vec[iqc_pkg::B_TB +: 3] = ext_irq.ext_temp_b_irq;
		irq_vec[iqc_pkg::B_HV] = ext_irq.hv_supply_alarm;
	end

	// Sweep flag is sticky; the end-of-sweep pulse bypasses it and its mask
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_q <= 1'b0;
			pulse_cnt_q <= 3'h0;
			int_n <= 1'b1;
		end else begin
			flag_q <= (flag_q & ~st_clr) | sweep_done_q;
			if (sweep_done_q && adc_mode == 2'h3) begin
				pulse_cnt_q <= iqc_pkg::INT_PULSE_CYC; // [RULE2]
			end else if (pulse_cnt_q != 3'h0) begin
				pulse_cnt_q <= 3'(pulse_cnt_q - 3'h1);
			end
			// [RULE1] [RULE3] [RULE4] [RULE5] [RULE7] [RULE8] [RULE9] [RULE23]
			int_n <= ~((|(irq_vec & ~mask_q)) | (pulse_cnt_q != 3'h0));
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_UNMASKED_LOW: assert property ((|(irq_vec & ~mask_q)) |=> !int_n) // [RULE23]
		else $error("Unmasked source did not pull int_n low");
	AST_MASKED_HIGH: assert property (!(|(irq_vec & ~mask_q)) && pulse_cnt_q == 3'h0
		|=> int_n) // [RULE1]
		else $error("int_n low with every source masked");
	AST_SWEEP_PULSE: assert property (sweep_done_q && adc_mode == 2'h3
		|=> ##1 !int_n [*5]) // [RULE2]
		else $error("End-of-sweep pulse shorter than 100 ns");
	AST_IDLE_MODE: assert property (adc_mode == 2'h0 |=> !adc_cmd.start) // [RULE13]
		else $error("Conversion started in idle mode");
	AST_CONT_RESTART: assert property (adc_mode == 2'h3 && state_q == iqc_pkg::ADC_IDLE
		&& adc_cfg_q != 12'h000 |=> adc_cmd.start) // [RULE16]
		else $error("Continuous sweep did not restart");
	AST_CODE_NONE: assert property (edge_a_q[iqc_pkg::EDGE_A_LSB +: 2] == 2'h0
		&& !gpi_st_q[0] |=> !gpi_st_q[0]) // [RULE12]
		else $error("Status set on port with code 00");
	AST_RISE_SET: assert property (edge_a_q[iqc_pkg::EDGE_A_LSB +: 2] == 2'h1
		&& gpi_in[0] && !gpi_prev_q[0] |=> gpi_st_q[0]) // [RULE11]
		else $error("Rising edge missed on port 0");
	AST_MISSED_MASK: assert property ($fell(mask_q[iqc_pkg::B_GDM])
		|-> !mask_q[iqc_pkg::B_GDR]) // [RULE6]
		else $error("Event-missed mask cleared while event-ready mask set");
	AST_PRESET_A: assert property (dac_cmd.stb && $past(dac_mode) == 2'h2
		|-> dac_cmd.value == $past(preset_a_q)) // [RULE20]
		else $error("Preset A not driven in mode 10");

endmodule

// [testbench/iqc_host_model.sv]
// Host-side model that times how long the interrupt line stays low
`timescale 1ns/1ns
module iqc_host_model (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Interrupt line and measured low time
	input  wire logic       int_n,
	output logic      [7:0] low_len
);
	logic [7:0] run_q;

	// Length of the last finished low run; sweep pulses show as short runs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_q <= 8'h00;
			low_len <= 8'h00;
		end else if (!int_n) begin
			run_q <= run_q + 8'h01;
		end else begin
			run_q <= 8'h00;
			if (run_q != 8'h00) low_len <= run_q;
		end
	end
endmodule

// [testbench/irq_mask_and_conversion_control_tb.sv]
// Self-checking bench for the interrupt and conversion control block
`timescale 1ns/1ns
module irq_mask_and_conversion_control_tb;
	// ****************************************
	// Signals
	// ****************************************
	logic                   aclk = 1'h0, aresetn = 1'h0, trig = 1'h0;
	logic                   awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
	logic                   awready, wready, bvalid, arready, rvalid, int_n;
	logic [7:0]             awaddr = 8'h00, araddr = 8'h00, low_len;
	logic [31:0]            wdata = 32'h0, rdata, rd;
	logic [11:0]            gpi = 12'h000;
	logic [1:0]             bresp, rresp, br, rr;
	logic                   dnew = 1'h0;
	logic [3:0]             dport = 4'h0;
	iqc_pkg::iqc_ext_irq_t  ext = '0;
	iqc_pkg::iqc_conv_cmd_t adc_cmd;
	iqc_pkg::iqc_dac_cmd_t  dac_cmd, dq[$];
	logic [3:0]             aq[$];
	int                     tq[$], cy = 0, fail_count = 0, check_count = 0;
	localparam logic [7:0]  M = iqc_pkg::OFS_MASK, S = iqc_pkg::OFS_STATUS;
	localparam logic [7:0]  D = iqc_pkg::OFS_DEVCTL;

	always #10 aclk = ~aclk;
	// Log conversion starts with their cycle, and output strobes
	always @(posedge aclk) begin
		cy++;
		if (adc_cmd.start === 1'h1) aq.push_back(adc_cmd.port);
		if (adc_cmd.start === 1'h1) tq.push_back(cy);
		if (dac_cmd.stb === 1'h1) dq.push_back(dac_cmd);
	end

	iqc_top DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(1'h1), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'h1),
		.conversion_trigger(trig), .gpi_in(gpi), .ext_irq(ext), .dac_new_data(dnew),
		.dac_new_port(dport), .int_n(int_n), .adc_cmd(adc_cmd), .dac_cmd(dac_cmd));
	iqc_host_model HOST (.aclk(aclk), .aresetn(aresetn), .int_n(int_n), .low_len(low_len));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic close_out();
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Bus waits are bounded; a hang ends the run
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		{awaddr, wdata, awvalid, wvalid} <= {a, d, 2'h3};
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			n++;
		end while (!bvalid && n < 40);
		br = bresp;
		if (n >= 40) chk(0, 1, "write hang");
		if (n >= 40) close_out();
	endtask
	task automatic rdr(input logic [7:0] a);
		int n;
		n = 0;
		{araddr, arvalid} <= {a, 1'h1};
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
			n++;
		end while (!rvalid && n < 40);
		rd = rdata;
		rr = rresp;
		if (n >= 40) chk(0, 1, "read hang");
		if (n >= 40) close_out();
	endtask
	task automatic pulse();
		trig <= 1'h1;
		cyc(3);
		trig <= 1'h0;
		cyc(3);
	endtask

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		cyc(16);
		aresetn <= 1'h1;
		cyc(1);
		// Each outside source alone, first masked then unmasked
		for (int j = 0; j < 13; j++) begin
			ext <= iqc_pkg::iqc_ext_irq_t'(13'h1 << j);
			cyc(3);
			chk(int_n, 1, "masked src");
			wr(M, ~(32'h1 << (j < 2 ? j + 1 : j + 3)));
			cyc(3);
			chk(int_n, 0, "open src");
			wr(M, 32'hffff);
		end
		ext <= '0;
		// Ports 0, 6 and 11 share each edge code; status fills though masked
		for (int c = 0; c < 4; c++) begin
			wr(iqc_pkg::OFS_EDGE_A, c << 4);
			wr(iqc_pkg::OFS_EDGE_B, c << 6);
			wr(iqc_pkg::OFS_EDGE_C, c);
			gpi <= 12'h841;
			cyc(3);
			chk(int_n, 1, "events masked");
			rdr(S);
			chk(rd & 32'hfff0000, c[0] ? 32'h8410000 : 0, "rise");
			gpi <= 12'h000;
			cyc(3);
			rdr(S);
			chk(rd & 32'hfff0000, c[1] ? 32'h8410000 : 0, "fall");
		end
		wr(M, 32'hfff7);
		gpi <= 12'h001;
		cyc(3);
		chk(int_n, 0, "event open");
		wr(M, 32'hffef);
		rdr(M);
		chk(rd, 32'hffff, "missed mask held");
		wr(M, 32'hffe7);
		rdr(M);
		chk(rd, 32'hffe7, "missed mask freed");
		chk(br, iqc_pkg::RESP_OKAY, "write okay");
		// Unmapped addresses answer with an error and read as zero
		rdr(8'h28);
		chk(rr, iqc_pkg::RESP_SLVERR, "unmapped read resp");
		chk(rd, 32'h0, "unmapped read data");
		wr(8'h2c, 32'h1);
		chk(br, iqc_pkg::RESP_SLVERR, "unmapped write resp");
		wr(M, 32'hffff);
		// One sweep of ports 5 and 7 at each rate
		wr(iqc_pkg::OFS_ADC_CFG, 32'h0a0);
		for (int r = 0; r < 4; r++) begin
			wr(D, r << 4 | 1);
			aq.delete();
			tq.delete();
			pulse();
			cyc(800);
			chk({aq.size(), aq[0], aq[1]}, 32'h257, "sweep");
			chk(tq[1] - tq[0], 50000 / (r == 0 ? 200 : r == 1 ? 250 : r == 2 ? 333 : 400), "rate");
		end
		wr(M, 32'hfffe);
		cyc(3);
		chk(int_n, 0, "flag open");
		wr(M, 32'hffff);
		cyc(3);
		chk(int_n, 1, "flag masked");
		wr(D, 32'h32);
		aq.delete();
		// Triggers during a conversion are dropped, so space them past one period
		repeat (3) begin
			pulse();
			cyc(130);
		end
		cyc(300);
		chk({aq.size(), aq[0], aq[1], aq[2]}, 32'h3575, "single");
		wr(D, 32'h30);
		aq.delete();
		pulse();
		cyc(300);
		chk(aq.size(), 0, "idle");
		wr(D, 32'h33);
		aq.delete();
		pulse();
		cyc(900);
		chk(low_len, 32'(iqc_pkg::INT_PULSE_CYC), "sweep pulse");
		chk({aq[0], aq[1], aq[2], aq[3]}, 32'h5757, "continuous");
		// Output modes on ports 3 and 9
		wr(iqc_pkg::OFS_DAC_CFG, 32'h208);
		wr(iqc_pkg::OFS_PRESET_A, 32'h5a5);
		wr(iqc_pkg::OFS_PRESET_B, 32'h3c3);
		for (int m = 0; m < 2; m++) begin
			wr(D, m << 2);
			cyc(60);
			dq.delete();
			cyc(110);
			chk(dq[0].port ^ dq[1].port, 32'ha, "refresh order");
			chk(dq[0].preset, 0, "no preset");
			// Immediate mode: new data on port 9 is refreshed next, then port 3
			if (m) begin
				dnew <= 1'h1; // single request, no second one follows
				dport <= 4'h9;
				cyc(1);
				dnew <= 1'h0;
				cyc(1);
				dq.delete();
				cyc(55);
				chk({dq[0].port, dq[1].port}, 32'h93, "jump queue");
			end
			wr(D, (m + 2) << 2 | 1);
			cyc(60);
			dq.delete();
			cyc(110);
			chk({dq[1].preset, dq[1].value}, m ? 32'h13c3 : 32'h15a5, "preset");
		end
		close_out();
	end
endmodule
